// *** hdl/mma_pkg.sv ***
/*
 * Shared constants and carrier types for the multi-master I2C port:
 * register offsets, reset values, field layouts and bit counts.
 * Assumes a 32-bit APB master with byte addresses, one word per register.
 */
package mma_pkg;

    // ========================================
    // Register byte offsets
    localparam logic [7:0] MMA_OFS_BUF  = 8'h00;
    localparam logic [7:0] MMA_OFS_CTRL = 8'h04;
    localparam logic [7:0] MMA_OFS_STAT = 8'h08;
    localparam logic [7:0] MMA_OFS_DIR  = 8'h0C;
    localparam logic [7:0] MMA_OFS_EVT  = 8'h10;
    localparam logic [7:0] MMA_OFS_OWN  = 8'h14;

    // ========================================
    // Field positions
    localparam int MMA_DIR_SDA  = 7;
    localparam int MMA_DIR_SCL  = 6;
    localparam int MMA_EVT_FLAG = 0;
    localparam int MMA_EVT_EN   = 1;
    localparam int MMA_EVT_ARB  = 2;

    // ========================================
    // Reset values and codes
    localparam logic [7:0] MMA_CTRL_RST     = 8'h00;
    localparam logic [1:0] MMA_DIR_RST      = 2'h3;
    localparam logic [6:0] MMA_OWN_RST      = 7'h00;
    localparam logic [3:0] MMA_MODE_M_ONLY  = 4'hB;
    localparam logic [3:0] MMA_BIT_ACK      = 4'h8;
    localparam logic [3:0] MMA_BIT_DONE     = 4'h9;
    localparam int         MMA_FIFO_WIDTH   = 8;
    localparam int         MMA_FIFO_DEPTH   = 8;

    // ========================================
    // Carrier types
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mma_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } mma_apb_rsp_s;

    typedef struct packed {
        logic       write_collision_flag;
        logic       ovf;
        logic       en;
        logic       clock_hold_release;
        logic [3:0] mode;
    } mma_ctrl_s;

endpackage : mma_pkg

// *** hdl/mma_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on pclk; in_ready low means full.
 */
`timescale 1ns/1ns
`default_nettype none
module mma_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } mma_fifo_st_s;

    mma_fifo_st_s s_q;
    mma_fifo_st_s s_d;
    logic         push;
    logic         pop;

    assign in_ready  = s_q.cnt != (AW+1)'(DEPTH);
    assign out_valid = s_q.cnt != '0;
    assign out_data  = s_q.mem[s_q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = s_q.wp + AW'(1);
        end
        if (pop) begin
            s_d.rp = s_q.rp + AW'(1);
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    chk_fifo_no_overrun: assert property (@(posedge pclk) disable iff (!presetn)
        !in_ready |=> s_q.cnt == (AW+1)'(DEPTH) || $past(pop))
        else $error("fifo count moved past full");
endmodule : mma_fifo
`default_nettype wire

// *** hdl/mma_port.sv ***
/*
 * Multi-master I2C port: bus-state tracking, firmware-driven master pins
 * with arbitration check, receive-only slave with address ack, clock hold.
 * Assumes SCL/SDA inputs are asynchronous wires with external pull-ups,
 * sampled here by pclk; APB master on pclk.
 *
// How it works
// R1: Reset or disable clears start and stop seen
// R2: Start and stop flags follow latest bus condition
// R3: Take bus only after stop or when idle
// R4: Stop raises event interrupt when enabled
// R5: Master compares SDA only while releasing it
// R6: SDA low while released loses arbitration
// R7: Slave logic keeps receiving after lost arbitration
// R8: Matching address is acknowledged as slave
// R9: Firmware retries data lost during data phase
// R10: Cleared clock hold pulls SCL low
// R11: Hold waits until SCL already sampled low
// R12: SCL held until hold bit set again
// R13: Firmware keeps sample and edge bits clear
// R14: Start, stop, each byte set event flag
// R15: Pins are open-drain lows by direction bits
// R16: Start/stop are SDA edges with SCL high
 */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module mma_port (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire mma_pkg::mma_apb_req_s apb_req,
    output mma_pkg::mma_apb_rsp_s      apb_rsp,
    input  wire logic                  scl_i,
    output logic                       scl_o,
    output logic                       scl_oe,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    output logic                       irq
);
    import mma_pkg::*;

    typedef struct packed {
        logic        apb_rdy;
        logic        apb_err;
        logic [31:0] apb_rdata;
        logic        scl_m1;
        logic        scl_m2;
        logic        scl_m3;
        logic        sda_m1;
        logic        sda_m2;
        logic        sda_m3;
        mma_ctrl_s   ctrl;
        logic [1:0]  smp_cke;
        logic        start_seen;
        logic        stop_seen;
        logic        data_not_addr;
        logic        rw_bit;
        logic        evt_flag;
        logic        evt_en;
        logic        irq;
        logic        dir_sda;
        logic        dir_scl;
        logic        master;
        logic        arb_lost;
        logic        arb_in_data;
        logic [7:0]  tx_last;
        logic [6:0]  own_addr;
        logic [7:0]  shreg;
        logic [3:0]  bitcnt;
        logic        addr_phase;
        logic        addressed;
        logic        ack_drive;
        logic        stretch;
        logic        sda_oe;
        logic        scl_oe;
    } mma_st_s;

    mma_st_s    s_q;
    mma_st_s    s_d;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       setup;
    logic       wr;
    logic       rd;
    logic       bus_free;
    logic       byte_end;
    logic       ack_end;
    logic       addr_match;
    logic       slave_en;
    logic       lose;
    logic       push_valid;
    logic       push_ready;
    logic       pop_valid;
    logic       pop_ready;
    logic [7:0] pop_data;
    logic       dir_refused;

    // ========================================
    // Bus condition detection on synchronised lines
    assign scl_rise   = s_q.scl_m2 & ~s_q.scl_m3;
    assign scl_fall   = ~s_q.scl_m2 & s_q.scl_m3;
    assign start_det  = s_q.scl_m2 & s_q.scl_m3 & ~s_q.sda_m2 & s_q.sda_m3; // R16
    assign stop_det   = s_q.scl_m2 & s_q.scl_m3 & s_q.sda_m2 & ~s_q.sda_m3; // R16
    assign bus_free   = s_q.stop_seen | (~s_q.start_seen & ~s_q.stop_seen); // R3
    assign byte_end   = scl_fall & (s_q.bitcnt == MMA_BIT_ACK);
    assign ack_end    = scl_fall & (s_q.bitcnt == MMA_BIT_DONE);
    assign addr_match = s_q.addr_phase & (s_q.shreg[7:1] == s_q.own_addr);
    assign slave_en   = s_q.ctrl.en & (s_q.ctrl.mode != MMA_MODE_M_ONLY);
    // Only a released SDA is checked against the line
    assign lose = s_q.ctrl.en & s_q.master & s_q.dir_sda & scl_rise & ~s_q.sda_m2; // R5

    // ========================================
    // APB decode
    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr    = apb_req.psel & apb_req.penable & s_q.apb_rdy & apb_req.pwrite;
    assign rd    = apb_req.psel & apb_req.penable & s_q.apb_rdy & ~apb_req.pwrite;
    assign dir_refused = wr & (apb_req.paddr == MMA_OFS_DIR) & ~s_q.master & ~bus_free
                       & ~(apb_req.pwdata[MMA_DIR_SDA] & apb_req.pwdata[MMA_DIR_SCL]);

    assign push_valid = byte_end & slave_en & s_q.addressed & ~s_q.rw_bit & ~s_q.addr_phase;
    assign pop_ready  = rd & (apb_req.paddr == MMA_OFS_BUF);

    // ========================================
    // Receive buffer
    mma_fifo #(
        .WIDTH (MMA_FIFO_WIDTH),
        .DEPTH (MMA_FIFO_DEPTH)
    ) u_rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (s_q.shreg),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // ========================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.scl_m1 = scl_i;
        s_d.scl_m2 = s_q.scl_m1;
        s_d.scl_m3 = s_q.scl_m2;
        s_d.sda_m1 = sda_i;
        s_d.sda_m2 = s_q.sda_m1;
        s_d.sda_m3 = s_q.sda_m2;

        // Register reads are captured in the setup phase
        s_d.apb_rdy = setup;
        s_d.apb_err = 1'b0;
        if (setup) begin
            s_d.apb_rdata = 32'h0000_0000;
            unique case (apb_req.paddr)
                MMA_OFS_BUF:  s_d.apb_rdata[7:0] = pop_valid ? pop_data : s_q.tx_last;
                MMA_OFS_CTRL: s_d.apb_rdata[7:0] = s_q.ctrl;
                MMA_OFS_STAT: s_d.apb_rdata[7:0] = {s_q.smp_cke, s_q.data_not_addr,
                                  s_q.stop_seen, s_q.start_seen, s_q.rw_bit,
                                  1'b0, pop_valid};
                MMA_OFS_DIR:  s_d.apb_rdata[7:6] = {s_q.dir_sda, s_q.dir_scl};
                MMA_OFS_EVT:  s_d.apb_rdata[3:0] = {s_q.arb_in_data, s_q.arb_lost,
                                  s_q.evt_en, s_q.evt_flag};
                MMA_OFS_OWN:  s_d.apb_rdata[6:0] = s_q.own_addr;
                default:      s_d.apb_err = 1'b1;
            endcase
        end

        // Register writes
        if (wr) begin
            unique case (apb_req.paddr)
                MMA_OFS_BUF:  s_d.tx_last = apb_req.pwdata[7:0];
                MMA_OFS_CTRL: s_d.ctrl = mma_ctrl_s'(apb_req.pwdata[7:0]);
                MMA_OFS_STAT: s_d.smp_cke = apb_req.pwdata[7:6];
                MMA_OFS_DIR: begin
                    if (!dir_refused) begin
                        s_d.dir_sda = apb_req.pwdata[MMA_DIR_SDA]; // R15
                        s_d.dir_scl = apb_req.pwdata[MMA_DIR_SCL]; // R15
                        if (!(apb_req.pwdata[MMA_DIR_SDA] & apb_req.pwdata[MMA_DIR_SCL])) begin
                            s_d.master = 1'b1; // R3
                        end
                    end
                end
                MMA_OFS_EVT: begin
                    s_d.evt_en = apb_req.pwdata[MMA_EVT_EN];
                    if (apb_req.pwdata[MMA_EVT_FLAG]) begin
                        s_d.evt_flag = 1'b0;
                    end
                    if (apb_req.pwdata[MMA_EVT_ARB]) begin
                        s_d.arb_lost = 1'b0;
                    end
                end
                MMA_OFS_OWN:  s_d.own_addr = apb_req.pwdata[6:0];
                default: ;
            endcase
        end
        // Busy bus: a drive-low request is refused and flagged
        if (dir_refused) begin
            s_d.ctrl.write_collision_flag = 1'b1; // R3
        end

        // Bus conditions and slave receive; hardware sets win over clears
        if (start_det) begin
            s_d.start_seen    = 1'b1; // R2
            s_d.stop_seen     = 1'b0; // R2
            s_d.evt_flag      = 1'b1; // R14
            s_d.bitcnt        = 4'h0;
            s_d.addr_phase    = 1'b1;
            s_d.addressed     = 1'b0;
            s_d.ack_drive     = 1'b0;
            s_d.data_not_addr = 1'b0;
        end else if (stop_det) begin
            s_d.stop_seen  = 1'b1; // R2
            s_d.start_seen = 1'b0; // R2
            s_d.evt_flag   = 1'b1; // R4 R14
            s_d.master     = 1'b0;
            s_d.bitcnt     = 4'h0;
            s_d.addr_phase = 1'b0;
            s_d.addressed  = 1'b0;
            s_d.ack_drive  = 1'b0;
        end else begin
            // Shifting is independent of master state, so it survives a loss
            if (scl_rise && s_q.bitcnt < MMA_BIT_ACK) begin
                s_d.shreg  = {s_q.shreg[6:0], s_q.sda_m2}; // R7
                s_d.bitcnt = s_q.bitcnt + 4'h1;
            end
            if (byte_end) begin
                s_d.bitcnt = MMA_BIT_DONE;
                if (slave_en && addr_match) begin
                    s_d.addressed = 1'b1; // R8
                    s_d.rw_bit    = s_q.shreg[0];
                    s_d.ack_drive = 1'b1; // R8
                end else if (push_valid) begin
                    s_d.data_not_addr = 1'b1;
                    if (push_ready) begin
                        s_d.ack_drive = 1'b1; // R7
                    end else begin
                        s_d.ctrl.ovf = 1'b1;
                    end
                end
            end
            if (ack_end) begin
                s_d.bitcnt     = 4'h0;
                s_d.addr_phase = 1'b0;
                s_d.ack_drive  = 1'b0;
                s_d.evt_flag   = 1'b1; // R14
            end
        end

        // Lost arbitration releases both lines
        if (lose) begin
            s_d.dir_sda     = 1'b1; // R6
            s_d.dir_scl     = 1'b1; // R6
            s_d.master      = 1'b0; // R6
            s_d.arb_lost    = 1'b1; // R6
            s_d.arb_in_data = ~s_q.addr_phase;
        end

        // Clock hold: start pulling only once SCL is seen low
        if (s_d.ctrl.clock_hold_release) begin
            s_d.stretch = 1'b0; // R12
        end else if (!s_q.scl_m2) begin
            s_d.stretch = 1'b1; // R10 R11
        end

        if (!s_d.ctrl.en) begin
            s_d.start_seen = 1'b0; // R1
            s_d.stop_seen  = 1'b0; // R1
            s_d.master     = 1'b0;
            s_d.stretch    = 1'b0;
            s_d.ack_drive  = 1'b0;
            s_d.addressed  = 1'b0;
            s_d.addr_phase = 1'b0;
            s_d.bitcnt     = 4'h0;
        end

        s_d.irq    = s_d.evt_flag & s_d.evt_en; // R4 R14
        s_d.sda_oe = s_d.ctrl.en & (s_d.ack_drive | ~s_d.dir_sda); // R15
        s_d.scl_oe = s_d.ctrl.en & (s_d.stretch | ~s_d.dir_scl); // R10 R15
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.scl_m1   <= 1'b1;
            s_q.scl_m2   <= 1'b1;
            s_q.scl_m3   <= 1'b1;
            s_q.sda_m1   <= 1'b1;
            s_q.sda_m2   <= 1'b1;
            s_q.sda_m3   <= 1'b1;
            s_q.ctrl     <= mma_ctrl_s'(MMA_CTRL_RST);
            s_q.dir_sda  <= MMA_DIR_RST[1];
            s_q.dir_scl  <= MMA_DIR_RST[0];
            s_q.own_addr <= MMA_OWN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // Outputs
    assign apb_rsp.pready  = s_q.apb_rdy;
    assign apb_rsp.prdata  = s_q.apb_rdata;
    assign apb_rsp.pslverr = s_q.apb_err;
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = s_q.scl_oe;
    assign sda_oe = s_q.sda_oe;
    assign irq    = s_q.irq;

    // ========================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_disable_clears: assert property (!s_q.ctrl.en |-> !s_q.start_seen && !s_q.stop_seen) // R1
        else $error("start or stop seen while disabled");
    chk_start_flags: assert property (start_det && s_d.ctrl.en |=> // R2
        s_q.start_seen && !s_q.stop_seen)
        else $error("start not recorded");
    chk_stop_flags: assert property (stop_det && s_d.ctrl.en |=> // R2
        s_q.stop_seen && !s_q.start_seen)
        else $error("stop not recorded");
    chk_take_bus: assert property ($rose(s_q.master) |-> $past(bus_free) || $past(s_q.master)) // R3
        else $error("bus taken while busy");
    chk_stop_irq: assert property (stop_det && s_q.ctrl.en && s_q.evt_en && !wr |=> irq) // R4
        else $error("stop did not raise interrupt");
    chk_arb_release: assert property (lose && !wr |=> // R6
        !s_q.master && s_q.dir_sda && s_q.dir_scl ##0 s_q.arb_lost)
        else $error("lines not released after lost arbitration");
    chk_keep_shifting: assert property (lose && s_q.bitcnt < MMA_BIT_ACK && !stop_det |=> // R7
        s_q.bitcnt == $past(s_q.bitcnt) + 4'h1)
        else $error("slave stopped shifting after loss");
    chk_addr_ack: assert property (byte_end && slave_en && addr_match && !start_det // R8
        && !stop_det && s_d.ctrl.en |=> s_q.ack_drive [*1] ##1 sda_oe)
        else $error("matching address not acknowledged");
    chk_hold_low: assert property (s_q.stretch && !s_d.ctrl.clock_hold_release && s_d.ctrl.en |=> scl_oe) // R10
        else $error("SCL not held low");
    chk_hold_wait: assert property ($rose(s_q.stretch) |-> !$past(s_q.scl_m2)) // R11
        else $error("hold began with SCL high");
    chk_hold_release: assert property (s_q.stretch |-> !s_q.ctrl.clock_hold_release) // R12
        else $error("hold kept with bit set");
    chk_event_flag: assert property ((start_det || ack_end) && s_q.ctrl.en |=> s_q.evt_flag) // R14
        else $error("event flag not set");
    chk_open_drain: assert property (!s_q.dir_scl && s_q.ctrl.en && !lose && !wr |=> // R15
        scl_oe && !scl_o)
        else $error("SCL direction not driven low");

    cov_arb_lost:  cover property (lose);
    cov_addressed: cover property (byte_end && addr_match && slave_en);
    cov_stop_irq:  cover property (stop_det ##1 irq);
    cov_stretch:   cover property ($rose(s_q.stretch));
endmodule : mma_port
`default_nettype wire

// *** testbench/mma_bus_model.sv ***
/*
 * Stand-in for the other masters and slaves that share the two-wire bus.
 * Assumes the bench resolves open-drain lines with pull-ups; only lows driven.
 */
`timescale 1ns/1ns
`default_nettype none
module mma_bus_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_pull,
    output logic      sda_pull
);
    int half_ns = 62;
    int n_stuck = 0;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // ========================================
    // Line primitives
    task automatic pull(input logic scl_low, input logic sda_low);
        scl_pull = scl_low;
        sda_pull = sda_low;
    endtask : pull

    task automatic start_cond();
        sda_pull = 1'b1;
        #(half_ns);
        scl_pull = 1'b1;
        #(half_ns);
    endtask : start_cond

    task automatic stop_cond();
        sda_pull = 1'b1;
        #(half_ns);
        scl_pull = 1'b0;
        #(half_ns);
        sda_pull = 1'b0;
        #(half_ns);
    endtask : stop_cond

    // One clock pulse; a party still holding SCL low stretches it
    task automatic clk_bit(input logic b, output logic seen);
        int n;
        sda_pull = ~b;
        #(half_ns);
        scl_pull = 1'b0;
        n = 0;
        while (scl !== 1'b1 && n < 200) begin
            #10;
            n++;
        end
        if (scl !== 1'b1) begin
            n_stuck++;
        end
        #(half_ns + 1);
        seen = sda;
        scl_pull = 1'b1;
    endtask : clk_bit

    // Eight bits MSB first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic nack);
        logic x;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], x);
        end
        clk_bit(1'b1, nack);
    endtask : send_byte

endmodule : mma_bus_model
`default_nettype wire

// *** testbench/mma_port_tb.sv ***
/*
 * Self-checking bench for the multi-master port: APB tasks, one task per scenario.
 * Assumes pull-ups on both lines, resolved here from every party's enables.
 */
`timescale 1ns/1ns
`default_nettype none
module mma_port_tb;
    import mma_pkg::*;

    logic         pclk;
    logic         presetn;
    mma_apb_req_s req;
    mma_apb_rsp_s rsp;
    logic         scl_o;
    logic         scl_oe;
    logic         sda_o;
    logic         sda_oe;
    logic         irq;
    logic         m_scl;
    logic         m_sda;
    logic         scl_w;
    logic         sda_w;
    int           n_errors;
    int           n_compared;

    // ========================================
    // Clock, wires, instances
    always #5 pclk = ~pclk;
    assign scl_w = ~(scl_oe | m_scl);
    assign sda_w = ~(sda_oe | m_sda);

    mma_port u_mma_port (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq)
    );
    mma_bus_model u_mma_bus_model (
        .scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda)
    );

    // ========================================
    // Reporting and bus tasks
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) begin
            n++;
            if (n > 40) begin
                check("pready wait", 32'h0, 32'h1);
                complete_run();
            end
            @(posedge pclk);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'h0, d}, rd, err);
    endtask : wr

    // Upper bits are always compared against zero
    task automatic rc(input string what, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(what, rd & {24'hFFFFFF, m}, {24'h0, exp & m});
    endtask : rc

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    // ========================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        rc("ctrl", MMA_OFS_CTRL, 8'hFF, MMA_CTRL_RST);
        rc("status", MMA_OFS_STAT, 8'hFF, 8'h00);
        rc("dir", MMA_OFS_DIR, 8'hC0, {MMA_DIR_RST, 6'h00});
        rc("event", MMA_OFS_EVT, 8'hFF, 8'h00);
        rc("own", MMA_OFS_OWN, 8'hFF, {1'b0, MMA_OWN_RST});
        apb(1'b0, 8'h18, 32'h0, rd, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        check("pin levels", {30'h0, scl_o, sda_o}, 32'h0);
    endtask : t_reset

    task automatic t_events();
        wr(MMA_OFS_STAT, 8'h00);
        wr(MMA_OFS_CTRL, 8'h36);
        wr(MMA_OFS_EVT, 8'h02);
        u_mma_bus_model.start_cond();
        rc("start seen", MMA_OFS_STAT, 8'h18, 8'h08);
        rc("start flag", MMA_OFS_EVT, 8'h01, 8'h01);
        check("irq start", 32'(irq), 32'h1);
        wr(MMA_OFS_DIR, 8'h40);
        rc("busy take", MMA_OFS_DIR, 8'hC0, 8'hC0);
        rc("write_collision_flag", MMA_OFS_CTRL, 8'h80, 8'h80);
        wr(MMA_OFS_EVT, 8'h03);
        idle(2);
        check("irq clear", 32'(irq), 32'h0);
        u_mma_bus_model.stop_cond();
        idle(8);
        check("irq stop", 32'(irq), 32'h1);
        rc("stop seen", MMA_OFS_STAT, 8'h18, 8'h10);
        wr(MMA_OFS_EVT, 8'h01);
        wr(MMA_OFS_CTRL, 8'h36);
    endtask : t_events

    task automatic t_slave();
        logic nack;
        wr(MMA_OFS_OWN, 8'h2A);
        u_mma_bus_model.half_ns = 200;
        u_mma_bus_model.start_cond();
        u_mma_bus_model.send_byte(8'h54, nack);
        check("addr ack", 32'(nack), 32'h0);
        rc("addr not queued", MMA_OFS_STAT, 8'h25, 8'h00);
        u_mma_bus_model.half_ns = 62;
        for (int i = 0; i <= MMA_FIFO_DEPTH; i++) begin
            u_mma_bus_model.send_byte(8'hA0 + 8'(i), nack);
            check("data ack", 32'(nack), {31'h0, i == MMA_FIFO_DEPTH});
        end
        rc("overflow", MMA_OFS_CTRL, 8'h40, 8'h40);
        rc("byte flag", MMA_OFS_EVT, 8'h01, 8'h01);
        check("irq masked", 32'(irq), 32'h0);
        u_mma_bus_model.stop_cond();
        for (int i = 0; i < MMA_FIFO_DEPTH; i++) begin
            rc("drain", MMA_OFS_BUF, 8'hFF, 8'hA0 + 8'(i));
        end
        rc("empty", MMA_OFS_STAT, 8'h01, 8'h00);
        wr(MMA_OFS_CTRL, 8'h36);
    endtask : t_slave

    task automatic t_arb();
        wr(MMA_OFS_DIR, 8'h40);
        rc("take free", MMA_OFS_DIR, 8'hC0, 8'h40);
        wr(MMA_OFS_DIR, 8'h00);
        wr(MMA_OFS_DIR, 8'h40);
        idle(8);
        rc("low bit kept", MMA_OFS_EVT, 8'h04, 8'h00);
        wr(MMA_OFS_DIR, 8'h00);
        u_mma_bus_model.pull(1'b0, 1'b1);
        wr(MMA_OFS_DIR, 8'h80);
        wr(MMA_OFS_DIR, 8'hC0);
        idle(8);
        rc("arb lost", MMA_OFS_EVT, 8'h04, 8'h04);
        rc("dir released", MMA_OFS_DIR, 8'hC0, 8'hC0);
        check("oe released", {30'h0, scl_oe, sda_oe}, 32'h0);
        u_mma_bus_model.pull(1'b0, 1'b0);
        idle(8);
        wr(MMA_OFS_EVT, 8'h05);
        rc("arb cleared", MMA_OFS_EVT, 8'h04, 8'h00);
        wr(MMA_OFS_DIR, 8'h40);
        rc("retry take", MMA_OFS_DIR, 8'hC0, 8'h40);
        wr(MMA_OFS_DIR, 8'h00);
        wr(MMA_OFS_DIR, 8'h40);
        wr(MMA_OFS_DIR, 8'hC0);
    endtask : t_arb

    task automatic t_hold();
        wr(MMA_OFS_CTRL, 8'h26);
        idle(8);
        check("hold waits", 32'(scl_oe), 32'h0);
        u_mma_bus_model.pull(1'b1, 1'b0);
        idle(8);
        u_mma_bus_model.pull(1'b0, 1'b0);
        idle(8);
        check("clock held", {30'h0, scl_oe, scl_w}, 32'h2);
        wr(MMA_OFS_CTRL, 8'h36);
        idle(8);
        check("clock freed", {30'h0, scl_oe, scl_w}, 32'h1);
        rc("stop kept", MMA_OFS_STAT, 8'h18, 8'h10);
        wr(MMA_OFS_CTRL, 8'h00);
        rc("disable clears", MMA_OFS_STAT, 8'h18, 8'h00);
        check("scl stuck", 32'(u_mma_bus_model.n_stuck), 32'h0);
    endtask : t_hold

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        req = '0;
        n_errors = 0;
        n_compared = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_events();
        t_slave();
        t_arb();
        t_hold();
        complete_run();
    end

endmodule : mma_port_tb
`default_nettype wire
